// >>> design/irq_cond.sv
// interrupt flag conditions for proximity channels 2/3 and ambient light
`default_nettype none

// Behaviour
// RULE1 - prox2 enable bit 3, mode bits 7:6; off means no flag; mode 00 every sample
// RULE2 - prox2 mode 01 raises flag when the threshold is crossed
// RULE3 - prox2 mode 11 raises flag whenever sample is above threshold
// RULE4 - prox3 enable bit 4, mode in second register; off none; 00 every sample
// RULE5 - prox3 mode 01 raises flag when the threshold is crossed
// RULE6 - prox3 mode 11 raises flag whenever sample is above threshold
// RULE7 - ambient enable 01 with mode 000 sets flag 0 per visible sample
// RULE8 - enable 0 and mode 01: visible leaving window sets flag 0
// RULE9 - enable 1 and mode bits 2:1 10: visible entering window sets flag 1
// RULE10 - enable 0 and mode 11: infrared leaving window sets flag 0
// RULE11 - enable 1 and mode bits 2:1 11: infrared entering window sets flag 1
// RULE12 - no per-sample interrupt for infrared alone; only visible per-sample
// RULE13 - host programs only listed ambient enable/mode combinations
// RULE14 - ambient window decisions use hysteresis and history checking
// RULE15 - ambient hysteresis is an 8-bit compressed value
// RULE16 - ambient low and high thresholds are compressed values
// RULE17 - proximity threshold decisions use hysteresis and history checking
// RULE18 - proximity hysteresis is an 8-bit compressed value
// RULE19 - prox2 and prox3 thresholds are compressed values
// RULE20 - interrupt output active when any flag and its enable are set
// RULE21 - writing one to a flag position clears only that flag
// RULE22 - conditions evaluated once per new sample; crossing is outcome change
module irq_cond (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic [7:0]  irq_enable_i,
    input  wire logic [7:0]  irq_mode_reg_a_i,
    input  wire logic [7:0]  irq_mode_reg_b_i,
    input  wire logic [7:0]  prox2_threshold_i,
    input  wire logic [7:0]  prox3_threshold_i,
    input  wire logic [7:0]  prox_hysteresis_i,
    input  wire logic [1:0]  prox_history_check_i,
    input  wire logic [7:0]  ambient_low_threshold_i,
    input  wire logic [7:0]  ambient_high_threshold_i,
    input  wire logic [7:0]  ambient_hysteresis_i,
    input  wire logic [1:0]  ambient_history_check_i,
    input  wire logic [15:0] prox2_sample_i,
    input  wire logic        prox2_valid_i,
    input  wire logic [15:0] prox3_sample_i,
    input  wire logic        prox3_valid_i,
    input  wire logic [15:0] ambient_visible_result_i,
    input  wire logic        ambient_visible_valid_i,
    input  wire logic [15:0] ambient_infrared_result_i,
    input  wire logic        ambient_infrared_valid_i,
    input  wire logic [7:0]  status_clear_i,
    output logic             prox2_flag_o,
    output logic             prox3_flag_o,
    output logic [1:0]       ambient_flag_o,
    output logic             irq_o
);

    // ------------------------------------------------------------
    // compressed value expansion and saturating arithmetic
    // ------------------------------------------------------------
    function automatic logic [15:0] expand(input logic [7:0] code);
        logic [3:0]  ex;
        logic [31:0] wide;
        ex   = code[7:irq_cond_pkg::CMP_EXP_LSB];
        wide = 32'h0;
        if (ex == 4'h0)
        begin
            wide = {28'h0, code[irq_cond_pkg::CMP_MANT_W-1:0]};
        end
        else
        begin
            wide = {27'h0, 1'b1, code[irq_cond_pkg::CMP_MANT_W-1:0]} << (ex - 4'h1);
        end
        if (wide[31:16] != 16'h0)
        begin
            expand = 16'hffff;
        end
        else
        begin
            expand = wide[15:0];
        end
    endfunction

    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s[16])
        begin
            sat_add = 16'hffff;
        end
        else
        begin
            sat_add = s[15:0];
        end
    endfunction

    function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
        if (a > b)
        begin
            sat_sub = a - b;
        end
        else
        begin
            sat_sub = 16'h0;
        end
    endfunction

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    wire logic       prox2_irq_enable   = irq_enable_i[irq_cond_pkg::PROX2_EN_BIT];
    wire logic       prox3_irq_enable   = irq_enable_i[irq_cond_pkg::PROX3_EN_BIT];
    wire logic [1:0] ambient_irq_enable =
        irq_enable_i[irq_cond_pkg::AMB_EN_LSB +: 2];
    wire logic [1:0] prox2_irq_mode     =
        irq_mode_reg_a_i[irq_cond_pkg::PROX2_MODE_LSB +: 2];
    wire logic [1:0] prox3_irq_mode     =
        irq_mode_reg_b_i[irq_cond_pkg::PROX3_MODE_LSB +: 2];
    wire logic [2:0] ambient_irq_mode   =
        irq_mode_reg_a_i[irq_cond_pkg::AMB_MODE_LSB +: 3];

    // ambient source: mode bit 1 picks infrared over visible
    wire logic        amb_use_ir  = ambient_irq_mode[1];
    wire logic [15:0] amb_sample  =
        amb_use_ir ? ambient_infrared_result_i : ambient_visible_result_i;
    wire logic        amb_valid   =
        amb_use_ir ? ambient_infrared_valid_i : ambient_visible_valid_i;

    // ------------------------------------------------------------
    // per-channel comparison inputs
    // ------------------------------------------------------------
    wire logic [15:0] prox_hyst_v = expand(prox_hysteresis_i);       // RULE18
    wire logic [15:0] amb_hyst_v  = expand(ambient_hysteresis_i);    // RULE15
    wire logic [15:0] prox2_th_v  = expand(prox2_threshold_i);       // RULE19
    wire logic [15:0] prox3_th_v  = expand(prox3_threshold_i);       // RULE19
    wire logic [15:0] amb_low_v   = expand(ambient_low_threshold_i); // RULE16
    wire logic [15:0] amb_high_v  = expand(ambient_high_threshold_i); // RULE16

    logic [15:0] ch_sample [irq_cond_pkg::NUM_CH];
    logic [15:0] ch_low    [irq_cond_pkg::NUM_CH];
    logic [15:0] ch_high   [irq_cond_pkg::NUM_CH];
    logic [15:0] ch_hyst   [irq_cond_pkg::NUM_CH];
    logic [1:0]  ch_hist   [irq_cond_pkg::NUM_CH];
    logic [irq_cond_pkg::NUM_CH-1:0] ch_valid;
    logic [irq_cond_pkg::NUM_CH-1:0] ch_window;

    assign ch_sample[irq_cond_pkg::CH_PROX2] = prox2_sample_i;
    assign ch_sample[irq_cond_pkg::CH_PROX3] = prox3_sample_i;
    assign ch_sample[irq_cond_pkg::CH_AMB]   = amb_sample;
    assign ch_low[irq_cond_pkg::CH_PROX2]    = prox2_th_v;
    assign ch_low[irq_cond_pkg::CH_PROX3]    = prox3_th_v;
    assign ch_low[irq_cond_pkg::CH_AMB]      = amb_low_v;
    assign ch_high[irq_cond_pkg::CH_PROX2]   = 16'hffff;
    assign ch_high[irq_cond_pkg::CH_PROX3]   = 16'hffff;
    assign ch_high[irq_cond_pkg::CH_AMB]     = amb_high_v;
    assign ch_hyst[irq_cond_pkg::CH_PROX2]   = prox_hyst_v;
    assign ch_hyst[irq_cond_pkg::CH_PROX3]   = prox_hyst_v;
    assign ch_hyst[irq_cond_pkg::CH_AMB]     = amb_hyst_v;
    assign ch_hist[irq_cond_pkg::CH_PROX2]   = prox_history_check_i;
    assign ch_hist[irq_cond_pkg::CH_PROX3]   = prox_history_check_i;
    assign ch_hist[irq_cond_pkg::CH_AMB]     = ambient_history_check_i;
    assign ch_valid  = {amb_valid, prox3_valid_i, prox2_valid_i};
    assign ch_window = 3'h4;

    // ------------------------------------------------------------
    // condition evaluators: hysteresis, history, edge detection
    // ------------------------------------------------------------
    logic [irq_cond_pkg::NUM_CH-1:0] ch_state_next;
    logic [irq_cond_pkg::NUM_CH-1:0] ch_rise;
    logic [irq_cond_pkg::NUM_CH-1:0] ch_fall;

    genvar g;
    generate
        for (g = 0; g < irq_cond_pkg::NUM_CH; g = g + 1)
        begin : gen_ch
            logic        state_reg;
            logic [1:0]  cnt_reg;
            logic [1:0]  cnt_next;
            // thresholds widen while inside, narrow while outside
            wire logic [15:0] low_h  = state_reg ? sat_sub(ch_low[g], ch_hyst[g])
                                                 : sat_add(ch_low[g], ch_hyst[g]);
            wire logic [15:0] high_h = state_reg ? sat_add(ch_high[g], ch_hyst[g])
                                                 : sat_sub(ch_high[g], ch_hyst[g]);
            wire logic raw    = (ch_sample[g] > low_h) &&
                                (!ch_window[g] || (ch_sample[g] < high_h));
            wire logic differ = raw != state_reg;
            // outcome must disagree on hist+1 samples in a row
            wire logic commit = ch_valid[g] && differ && (cnt_reg >= ch_hist[g]); // RULE14 RULE17

            assign ch_state_next[g] = commit ? raw : state_reg;
            assign ch_rise[g]       = commit && raw;    // RULE22
            assign ch_fall[g]       = commit && !raw;   // RULE22
            assign cnt_next = !ch_valid[g] ? cnt_reg :
                              (commit || !differ) ? irq_cond_pkg::CNT_RST :
                              cnt_reg + 2'h1;

            always_ff @(posedge mclk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    state_reg <= 1'b0;
                end
                else
                begin
                    state_reg <= ch_state_next[g];
                end
            end

            always_ff @(posedge mclk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    cnt_reg <= irq_cond_pkg::CNT_RST;
                end
                else
                begin
                    cnt_reg <= cnt_next;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // proximity flag set conditions
    // ------------------------------------------------------------
    wire logic p2_every = prox2_irq_mode == irq_cond_pkg::PROX_MODE_EVERY;
    wire logic p2_cross = prox2_irq_mode == irq_cond_pkg::PROX_MODE_CROSS;
    wire logic p2_above = prox2_irq_mode == irq_cond_pkg::PROX_MODE_ABOVE;
    wire logic p3_every = prox3_irq_mode == irq_cond_pkg::PROX_MODE_EVERY;
    wire logic p3_cross = prox3_irq_mode == irq_cond_pkg::PROX_MODE_CROSS;
    wire logic p3_above = prox3_irq_mode == irq_cond_pkg::PROX_MODE_ABOVE;

    wire logic p2_chg = ch_rise[irq_cond_pkg::CH_PROX2] | ch_fall[irq_cond_pkg::CH_PROX2];
    wire logic p3_chg = ch_rise[irq_cond_pkg::CH_PROX3] | ch_fall[irq_cond_pkg::CH_PROX3];

    wire logic prox2_set = prox2_irq_enable && prox2_valid_i && (   // RULE1
        p2_every ||                                                 // RULE1
        (p2_cross && p2_chg) ||                                     // RULE2
        (p2_above && ch_state_next[irq_cond_pkg::CH_PROX2]));       // RULE3

    wire logic prox3_set = prox3_irq_enable && prox3_valid_i && (   // RULE4
        p3_every ||                                                 // RULE4
        (p3_cross && p3_chg) ||                                     // RULE5
        (p3_above && ch_state_next[irq_cond_pkg::CH_PROX3]));       // RULE6

    // ------------------------------------------------------------
    // ambient flag set conditions
    // ------------------------------------------------------------
    // per-sample works on visible results only
    wire logic amb_per_sample = ambient_visible_valid_i &&                   // RULE12
        (ambient_irq_enable == irq_cond_pkg::AMB_EN_SAMPLE) &&              // RULE7
        (ambient_irq_mode == irq_cond_pkg::AMB_MODE_SAMPLE);                // RULE7
    wire logic amb_exit = ch_fall[irq_cond_pkg::CH_AMB];
    wire logic amb_enter = ch_rise[irq_cond_pkg::CH_AMB];

    wire logic amb_vis_exit  = ambient_irq_enable[0] &&
        (ambient_irq_mode[1:0] == 2'h1) && amb_exit;                        // RULE8
    wire logic amb_ir_exit   = ambient_irq_enable[0] &&
        (ambient_irq_mode[1:0] == 2'h3) && amb_exit;                        // RULE10
    wire logic amb_vis_enter = ambient_irq_enable[1] &&
        (ambient_irq_mode[2:1] == 2'h2) && amb_enter;                       // RULE9
    wire logic amb_ir_enter  = ambient_irq_enable[1] &&
        (ambient_irq_mode[2:1] == 2'h3) && amb_enter;                       // RULE11

    wire logic [1:0] amb_set = {amb_vis_enter | amb_ir_enter,
                                amb_per_sample | amb_vis_exit | amb_ir_exit};

    // ------------------------------------------------------------
    // sticky flags: set wins over a same-cycle clear
    // ------------------------------------------------------------
    logic       prox2_flag_reg;
    logic       prox3_flag_reg;
    logic [1:0] ambient_flag_reg;
    logic       irq_reg;

    wire logic       prox2_flag_next = prox2_set ||
        (prox2_flag_reg && !status_clear_i[irq_cond_pkg::PROX2_FLAG_BIT]);  // RULE21
    wire logic       prox3_flag_next = prox3_set ||
        (prox3_flag_reg && !status_clear_i[irq_cond_pkg::PROX3_FLAG_BIT]);  // RULE21
    wire logic [1:0] ambient_flag_next = amb_set |
        (ambient_flag_reg & ~status_clear_i[irq_cond_pkg::AMB_FLAG_LSB +: 2]); // RULE21

    wire logic irq_next =
        (prox2_flag_next && prox2_irq_enable) ||                            // RULE20
        (prox3_flag_next && prox3_irq_enable) ||                            // RULE20
        |(ambient_flag_next & ambient_irq_enable);                          // RULE20

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            prox2_flag_reg <= irq_cond_pkg::FLAG_RST;
        end
        else
        begin
            prox2_flag_reg <= prox2_flag_next;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            prox3_flag_reg <= irq_cond_pkg::FLAG_RST;
        end
        else
        begin
            prox3_flag_reg <= prox3_flag_next;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ambient_flag_reg <= {2{irq_cond_pkg::FLAG_RST}};
        end
        else
        begin
            ambient_flag_reg <= ambient_flag_next;
        end
    end

    // ------------------------------------------------------------
    // interrupt output register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= irq_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prox2_flag_o   = prox2_flag_reg;
    assign prox3_flag_o   = prox3_flag_reg;
    assign ambient_flag_o = ambient_flag_reg;
    assign irq_o          = irq_reg;

endmodule // irq_cond
`default_nettype wire

// >>> design/irq_cond_pkg.sv
// constants for the channel interrupt condition block
`default_nettype none
package irq_cond_pkg;
    // enable register field positions
    localparam int AMB_EN_LSB    = 0;
    localparam int PROX2_EN_BIT  = 3;
    localparam int PROX3_EN_BIT  = 4;
    // mode register field positions
    localparam int AMB_MODE_LSB  = 0;
    localparam int PROX2_MODE_LSB = 6;
    localparam int PROX3_MODE_LSB = 0;
    // status flag positions
    localparam int AMB_FLAG_LSB  = 0;
    localparam int PROX2_FLAG_BIT = 3;
    localparam int PROX3_FLAG_BIT = 4;
    // proximity mode codes
    localparam logic [1:0] PROX_MODE_EVERY = 2'h0;
    localparam logic [1:0] PROX_MODE_CROSS = 2'h1;
    localparam logic [1:0] PROX_MODE_ABOVE = 2'h3;
    // ambient field codes
    localparam logic [1:0] AMB_EN_SAMPLE   = 2'h1;
    localparam logic [2:0] AMB_MODE_SAMPLE = 3'h0;
    // compressed format: exponent [7:4], mantissa [3:0]
    localparam int CMP_EXP_LSB   = 4;
    localparam int CMP_MANT_W    = 4;
    // channel indices of the condition evaluators
    localparam int CH_PROX2      = 0;
    localparam int CH_PROX3      = 1;
    localparam int CH_AMB        = 2;
    localparam int NUM_CH        = 3;
    // reset values
    localparam logic [1:0] CNT_RST  = 2'h0;
    localparam logic       FLAG_RST = 1'b0;
endpackage
`default_nettype wire

// >>> sim/host_model.sv
// host side model: issues write-one-to-clear strobes to the status flags
`default_nettype none
module host_model (
    input  wire logic       mclk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] mask_i,
    output var  logic [7:0] status_clear_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ---------------------------------------------
    // clear strobe
    // ---------------------------------------------
    initial status_clear_o = 8'h00;
    // one-cycle write of ones to the chosen flag positions
    always @(negedge mclk_i) status_clear_o <= go_i ? mask_i : 8'h00;
endmodule // host_model
`default_nettype wire

// >>> sim/irq_cond_assertions.sv
// concurrent checks on the channel interrupt condition ports
`default_nettype none
module irq_cond_assertions (
    input wire logic       mclk_i,
    input wire logic       rstn_i,
    input wire logic [7:0] irq_enable_i,
    input wire logic [7:0] irq_mode_reg_a_i,
    input wire logic [7:0] irq_mode_reg_b_i,
    input wire logic       prox2_valid_i,
    input wire logic       prox3_valid_i,
    input wire logic       ambient_visible_valid_i,
    input wire logic       ambient_infrared_valid_i,
    input wire logic [7:0] status_clear_i,
    input wire logic       prox2_flag_o,
    input wire logic       prox3_flag_o,
    input wire logic [1:0] ambient_flag_o,
    input wire logic       irq_o
);
    // ---------------------------------------------
    // flag and interrupt relations
    // ---------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    a_prox2_off_quiet: assert property (
        !irq_enable_i[3] && !prox2_flag_o |=> !prox2_flag_o)
        else $error("prox2 flag rose while disabled");
    a_prox2_every_sample: assert property (
        irq_enable_i[3] && irq_mode_reg_a_i[7:6] == 2'h0 && prox2_valid_i |=> prox2_flag_o)
        else $error("prox2 per-sample flag missing");
    a_prox3_every_sample: assert property (
        irq_enable_i[4] && irq_mode_reg_b_i[1:0] == 2'h0 && prox3_valid_i |=> prox3_flag_o)
        else $error("prox3 per-sample flag missing");
    a_prox3_flag_sticky: assert property (
        prox3_flag_o && !status_clear_i[4] |=> prox3_flag_o)
        else $error("prox3 flag dropped without clear");
    a_prox2_clear_works: assert property (
        status_clear_i[3] && !prox2_valid_i |=> !prox2_flag_o)
        else $error("prox2 flag not cleared");
    a_amb_clear_works: assert property (
        status_clear_i[1:0] == 2'h3 && !ambient_visible_valid_i && !ambient_infrared_valid_i
        |=> ambient_flag_o == 2'h0) else $error("ambient not cleared");
    a_prox3_needs_sample: assert property ($rose(prox3_flag_o) |-> $past(prox3_valid_i))
        else $error("prox3 flag rose without a sample");
    a_irq_follows_flags: assert property (
        irq_o == |({prox3_flag_o, prox2_flag_o, ambient_flag_o}
        & $past({irq_enable_i[4:3], irq_enable_i[1:0]}))) else $error("irq output mismatch");
    a_amb_visible_sample: assert property (
        irq_enable_i[1:0] == 2'h1 && irq_mode_reg_a_i[2:0] == 3'h0 && ambient_visible_valid_i
        |=> ambient_flag_o[0]) else $error("ambient sample flag missing");
    a_amb_ir_alone: assert property (
        irq_enable_i[1:0] == 2'h1 && irq_mode_reg_a_i[2:0] == 3'h0
        && !ambient_visible_valid_i && ambient_flag_o == 2'h0 |=> ambient_flag_o == 2'h0)
        else $error("ambient flag without visible sample");
endmodule // irq_cond_assertions
bind irq_cond irq_cond_assertions i_irq_cond_assertions (.mclk_i, .rstn_i, .irq_enable_i,
    .irq_mode_reg_a_i, .irq_mode_reg_b_i, .prox2_valid_i, .prox3_valid_i, .ambient_visible_valid_i,
    .ambient_infrared_valid_i, .status_clear_i, .prox2_flag_o, .prox3_flag_o, .ambient_flag_o,
    .irq_o);
`default_nettype wire

// >>> sim/irq_cond_test.sv
// self-checking bench for the channel interrupt condition block
`default_nettype none
module irq_cond_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ---------------------------------------------
    // stimulus and checks
    // ---------------------------------------------
    typedef struct packed {logic ch3; logic en; logic [1:0] md; logic [15:0] v1; logic e1;
        logic [15:0] v2; logic e2;} prow_type;
    typedef struct packed {logic [1:0] en; logic [2:0] md; logic ir; logic [15:0] v1;
        logic [15:0] v2; logic [1:0] ex;} arow_type;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] en = 8'h00, ma = 8'h00, mb = 8'h00, phy = 8'h00, ahy = 8'h00, cmask = 8'h00;
    logic [1:0] phist = 2'h0;
    logic [15:0] p2s = 16'h0, p3s = 16'h0, vis = 16'h0, ir = 16'h0;
    logic p2v = 1'b0, p3v = 1'b0, visv = 1'b0, irv = 1'b0, go = 1'b0;
    wire logic f2, f3, irq;
    wire logic [1:0] fa;
    wire logic [7:0] clr;
    // selects which proximity flag the table row looks at
    logic s3 = 1'b0;
    wire logic pf = s3 ? f3 : f2;
    int error_cnt = 0;
    int checked = 0;
    prow_type pt[11] = '{'{0,0,0,9,0,9,0}, '{0,1,0,2,1,2,1}, '{0,1,1,9,1,10,0}, '{0,1,1,2,0,9,1},
        '{0,1,3,9,1,9,1}, '{0,1,3,2,0,5,0}, '{0,1,2,9,0,2,0}, '{1,0,0,40,0,40,0},
        '{1,1,0,1,1,1,1}, '{1,1,1,35,1,2,1}, '{1,1,3,34,0,35,1}};
    // only listed ambient combinations are programmed
    arow_type at[8] = '{'{0,0,0,15,45,0}, '{1,0,0,15,45,1}, '{1,1,0,15,45,1},
        '{1,1,0,5,45,0}, '{2,4,0,5,15,2}, '{1,3,1,15,45,1}, '{2,6,1,5,15,2}, '{1,0,1,15,45,0}};
    always #50 mclk_i = ~mclk_i;
    irq_cond i_irq_cond (.mclk_i(mclk_i), .rstn_i(rstn_i), .irq_enable_i(en),
        .irq_mode_reg_a_i(ma), .irq_mode_reg_b_i(mb), .prox2_threshold_i(8'h05),
        .prox3_threshold_i(8'h21), .prox_hysteresis_i(phy), .prox_history_check_i(phist),
        .ambient_low_threshold_i(8'h0a), .ambient_high_threshold_i(8'h25),
        .ambient_hysteresis_i(ahy), .ambient_history_check_i(2'h0), .prox2_sample_i(p2s),
        .prox2_valid_i(p2v), .prox3_sample_i(p3s), .prox3_valid_i(p3v),
        .ambient_visible_result_i(vis), .ambient_visible_valid_i(visv),
        .ambient_infrared_result_i(ir), .ambient_infrared_valid_i(irv), .status_clear_i(clr),
        .prox2_flag_o(f2), .prox3_flag_o(f3), .ambient_flag_o(fa), .irq_o(irq));
    host_model i_host_model (.mclk_i(mclk_i), .go_i(go), .mask_i(cmask), .status_clear_o(clr));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic do_reset();
        @(negedge mclk_i) rstn_i <= 1'b0;
        repeat (3) @(negedge mclk_i);
        rstn_i <= 1'b1;
    endtask
    // one-cycle sample pulse; outputs are settled on return
    task automatic smp(input int ch, input logic [15:0] v);
        @(negedge mclk_i);
        case (ch)
            0: begin vis <= v; visv <= 1'b1; end
            1: begin ir <= v; irv <= 1'b1; end
            2: begin p2s <= v; p2v <= 1'b1; end
            default: begin p3s <= v; p3v <= 1'b1; end
        endcase
        @(negedge mclk_i) {visv, irv, p2v, p3v} <= 4'h0;
    endtask
    task automatic clr_req(input logic [7:0] m);
        @(negedge mclk_i) {go, cmask} <= {1'b1, m};
        @(negedge mclk_i) go <= 1'b0;
        @(negedge mclk_i);
    endtask
    task automatic end_sim();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        do_reset();
        chk("reset outputs", 8'h00, {3'h0, irq, f3, f2, fa});
        for (int i = 0; i < 11; i++)
        begin
            do_reset();
            en <= pt[i].en ? (pt[i].ch3 ? 8'h10 : 8'h08) : 8'h00;
            s3 <= pt[i].ch3;
            {ma, mb} <= {pt[i].ch3 ? 2'h0 : pt[i].md, 12'h000, pt[i].md};
            smp(pt[i].ch3 ? 3 : 2, pt[i].v1);
            chk("prox flag first", {7'h0, pt[i].e1}, {7'h0, pf});
            chk("prox irq first", {7'h0, pt[i].e1}, {7'h0, irq});
            clr_req(8'h1b);
            smp(pt[i].ch3 ? 3 : 2, pt[i].v2);
            chk("prox flag second", {7'h0, pt[i].e2}, {7'h0, pf});
        end
        for (int i = 0; i < 8; i++)
        begin
            do_reset();
            {en, ma} <= {6'h00, at[i].en, 5'h00, at[i].md};
            smp(at[i].ir ? 1 : 0, at[i].v1);
            smp(at[i].ir ? 1 : 0, at[i].v2);
            chk("ambient flags", {6'h0, at[i].ex}, {6'h0, fa});
            chk("ambient irq", {7'h0, at[i].ex != 2'h0}, {7'h0, irq});
        end
        do_reset();
        {en, ma, phy, phist} <= {8'h08, 8'h40, 8'h03, 2'h1};
        smp(2, 16'd7);
        smp(2, 16'd9);
        chk("prox2 filtered", 8'h00, {7'h0, f2});
        smp(2, 16'd9);
        chk("prox2 after history", 8'h01, {7'h0, f2});
        clr_req(8'h10);
        chk("prox2 other clear", 8'h01, {7'h0, f2});
        @(negedge mclk_i) en <= 8'h00;
        @(negedge mclk_i);
        chk("irq masked", 8'h01, {6'h0, irq, f2});
        clr_req(8'h08);
        chk("prox2 cleared", 8'h00, {7'h0, f2});
        // window 10..42 widened to 7..45 once inside, narrowed to 13..39 outside
        do_reset();
        {en, ma, ahy} <= {8'h01, 8'h01, 8'h03};
        smp(0, 16'd20);
        smp(0, 16'd43);
        chk("ambient hysteresis hold", 8'h00, {6'h0, fa});
        smp(0, 16'd46);
        chk("ambient exit past hysteresis", 8'h01, {6'h0, fa});
        end_sim();
    end
endmodule // irq_cond_test
`default_nettype wire
